// >>> topc_top.sv
// Timer output control, count-clock prescaler and input edge selection.
// Assumes the counter core sits outside on sys_clk and supplies match and
// overflow strobes; the timer input pins are asynchronous.
//
// Summary of operation
// - Writing one to the software trigger bit issues a one-shot trigger unless the mode is stopped.
// - One-shot mode bit: zero successive pulses, one single pulse.
// - Second-register match inverts the output flip-flop when enabled.
// - Set/clear field: 00 hold, 01 clear, 10 set, 11 prohibited.
// - First-register match inverts the output flip-flop when enabled.
// - Output disabled holds timer pin low; enabled drives the flip-flop.
// - One-shot works only in free-running or clear-on-edge modes.
// - Set and clear bits always read as zero.
// - Software trigger bit clears itself and reads zero.
// - Second input edge field: 00 fall, 01 rise, 11 both.
// - First input edge field: 00 fall, 01 rise, 11 both.
// - Count clock: system, divide by 4, divide by 256, input edge.
// - High input after reset gives one rising edge on first enable.
// - Direction bits: zero output, one input; upper bits read one.
// - Mode field: 00x stopped, 01x free, 10x edge clear, 11x match clear.
`timescale 1ns/100ps
module topc_top
  import topc_pkg::*;
#(
  parameter int DIV_Q = DIV_QUARTER,
  parameter int DIV_S = DIV_SLOW
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Counter core side
  input wire logic [2:0] timer_mode_sel,
  input wire topc_core_ev_s core_ev,
  output topc_mode_e timer_mode,
  output logic count_enable,
  output logic oneshot_trigger,
  output logic in_a_valid_edge,
  output logic in_b_valid_edge,
  // Pins
  input wire logic timer_input_a,
  input wire logic timer_input_b,
  output logic timer_output_pin,
  output logic [PORT0_BITS-1:0] port0_direction,
  output logic output_flipflop
);

  function automatic topc_mode_e decode_mode(input logic [2:0] sel);
    case (sel[2:1])
      2'b00: decode_mode = TOPC_STOPPED;
      2'b01: decode_mode = TOPC_FREE_RUN;
      2'b10: decode_mode = TOPC_CLR_ON_EDGE;
      default: decode_mode = TOPC_CLR_ON_MATCH;
    endcase
  endfunction

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction

  // Register state
  topc_outctl_s out_ctrl;
  topc_presc_s presc;
  logic [PORT0_BITS-1:0] port_dir;
  logic bus_ack;
  logic [31:0] rd_data;

  // Output and one-shot state
  logic out_ff;
  logic next_out_ff;
  logic out_pin;
  logic oneshot_armed;
  logic next_oneshot_armed;
  logic [PRESC_W-1:0] presc_cnt;
  logic count_tick;
  logic trig_pulse;

  // Bus decode
  wire bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~bus_ack;
  wire wr_take = avs_write & bus_ack & avs_byteenable[0];
  wire sel_dir = addr_hit(avs_address, ADDR_PORT0_DIR);
  wire sel_presc = addr_hit(avs_address, ADDR_PRESC_EDGE);
  wire sel_outc = addr_hit(avs_address, ADDR_OUT_CTRL);
  wire wr_dir = wr_take & sel_dir;
  wire wr_presc = wr_take & sel_presc;
  wire wr_outc = wr_take & sel_outc;
  wire [7:0] wbyte = avs_writedata[7:0];

  // Read views
  wire [7:0] dir_view = PORT0_UPPER_ONES |
                        {{(8 - PORT0_BITS){1'b0}}, port_dir};
  wire [7:0] presc_view = {presc.in_b_edge, presc.in_a_edge, 2'b00,
                           presc.count_clk_sel};
  // Trigger, set and clear bits are not stored and always read zero
  wire [7:0] outc_view = {1'b0, 1'b0, out_ctrl.oneshot_mode_enable,
                          out_ctrl.second_match_invert_en,
                          1'b0, 1'b0,
                          out_ctrl.first_match_invert_en,
                          out_ctrl.out_enable};
  wire [7:0] rd_byte = sel_dir ? dir_view :
                       sel_presc ? presc_view :
                       sel_outc ? outc_view : 8'h00;

  // Mode and running state
  topc_mode_e mode_now;
  assign mode_now = decode_mode(timer_mode_sel);
  wire running = (mode_now != TOPC_STOPPED);
  wire oneshot_sel = out_ctrl.oneshot_mode_enable;

  // Input edge detection
  topc_edge_det u_edge_a (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pin(timer_input_a),
    .enable(running),
    .edge_sel(presc.in_a_edge),
    .valid_edge(in_a_valid_edge)
  );

  topc_edge_det u_edge_b (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pin(timer_input_b),
    .enable(running),
    .edge_sel(presc.in_b_edge),
    .valid_edge(in_b_valid_edge)
  );

  // Count clock selection
  localparam logic [PRESC_W-1:0] Q_MASK = PRESC_W'(DIV_Q - 1);
  localparam logic [PRESC_W-1:0] S_MASK = PRESC_W'(DIV_S - 1);
  wire q_tick = (presc_cnt & Q_MASK) == Q_MASK;
  wire s_tick = (presc_cnt & S_MASK) == S_MASK;
  logic next_count_tick;
  always_comb begin
    case (presc.count_clk_sel)
      CSEL_SYS: next_count_tick = running;
      CSEL_QUARTER: next_count_tick = running & q_tick;
      CSEL_SLOW: next_count_tick = running & s_tick;
      CSEL_EDGE_A: next_count_tick = in_a_valid_edge;
      default: next_count_tick = 1'b0;
    endcase
  end

  // One-shot trigger: software bit, or input edge in edge-clear mode
  wire sw_trig = wr_outc & wbyte[OC_ONESHOT_TRIG];
  wire edge_trig = oneshot_sel & (mode_now == TOPC_CLR_ON_EDGE) &
                   in_a_valid_edge;
  wire trig_now = (sw_trig | edge_trig) & running;

  // One-shot gating: inversions only between trigger and overflow.
  // In match-clear mode no overflow occurs, so the window never closes.
  always_comb begin
    next_oneshot_armed = oneshot_armed;
    if (!oneshot_sel || !running) begin
      next_oneshot_armed = 1'b0;
    end else if (trig_now) begin
      next_oneshot_armed = 1'b1;
    end else if (core_ev.overflow) begin
      next_oneshot_armed = 1'b0;
    end
  end

  wire inv_window = !oneshot_sel || oneshot_armed;
  wire inv_first = out_ctrl.first_match_invert_en & core_ev.match_first &
                   running & inv_window;
  wire inv_second = out_ctrl.second_match_invert_en & core_ev.match_second &
                    running & inv_window;
  wire lvl_set = wr_outc & wbyte[OC_LVL_SET];
  wire lvl_clr = wr_outc & wbyte[OC_LVL_CLEAR];

  // Software level write takes priority; prohibited 11 is ignored, so match inversion still applies
  always_comb begin
    next_out_ff = out_ff;
    if (lvl_set & ~lvl_clr) begin
      next_out_ff = 1'b1;
    end else if (lvl_clr & ~lvl_set) begin
      next_out_ff = 1'b0;
    end else if (inv_first ^ inv_second) begin
      next_out_ff = ~out_ff;
    end
  end

  // Enable may change in the same write, so the pin uses its next value
  wire next_out_en = wr_outc ? wbyte[OC_OUT_EN] : out_ctrl.out_enable;
  wire next_pin = next_out_en & next_out_ff;

  // Bus handshake and read data
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_ack <= 1'b0;
      rd_data <= 32'h0000_0000;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
      if (avs_read & ~bus_ack) begin
        rd_data <= {24'h00_0000, rd_byte};
      end
    end
  end
  assign avs_readdata = rd_data;

  // Register writes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_ctrl <= topc_outctl_s'({RST_OUT_CTRL[OC_ONESHOT_MODE],
                                 RST_OUT_CTRL[OC_INV_SECOND],
                                 RST_OUT_CTRL[OC_INV_FIRST],
                                 RST_OUT_CTRL[OC_OUT_EN]});
    end else if (wr_outc) begin
      out_ctrl.oneshot_mode_enable <= wbyte[OC_ONESHOT_MODE];
      out_ctrl.second_match_invert_en <= wbyte[OC_INV_SECOND];
      out_ctrl.first_match_invert_en <= wbyte[OC_INV_FIRST];
      out_ctrl.out_enable <= wbyte[OC_OUT_EN];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      presc <= topc_presc_s'({RST_PRESC_EDGE[7:4], RST_PRESC_EDGE[1:0]});
    end else if (wr_presc) begin
      presc.in_b_edge <= wbyte[PE_IN_B_EDGE_LO +: 2];
      presc.in_a_edge <= wbyte[PE_IN_A_EDGE_LO +: 2];
      presc.count_clk_sel <= wbyte[PE_CLK_SEL_LO +: 2];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_dir <= RST_PORT0_DIR[PORT0_BITS-1:0];
    end else if (wr_dir) begin
      port_dir <= wbyte[PORT0_BITS-1:0];
    end
  end

  // Prescaler runs only with the counter so each start is phase-aligned
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      presc_cnt <= '0;
      count_tick <= 1'b0;
    end else begin
      presc_cnt <= running ? presc_cnt + 1'b1 : '0;
      count_tick <= next_count_tick;
    end
  end

  // Output flip-flop, pin and one-shot state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_ff <= 1'b0;
      out_pin <= 1'b0;
      oneshot_armed <= 1'b0;
      trig_pulse <= 1'b0;
    end else begin
      out_ff <= next_out_ff;
      out_pin <= next_pin;
      oneshot_armed <= next_oneshot_armed;
      trig_pulse <= trig_now;
    end
  end

  assign timer_mode = mode_now;
  assign count_enable = count_tick;
  assign oneshot_trigger = trig_pulse;
  assign timer_output_pin = out_pin;
  assign port0_direction = port_dir;
  assign output_flipflop = out_ff;

endmodule // topc_top

// >>> topc_pkg.sv
// Shared constants and carriers for the timer output and prescaler block.
// Assumes a 20 MHz system clock and an Avalon-MM byte-addressed register bus.
package topc_pkg;

  localparam int CLK_HZ = 20_000_000;

  // Register indexes as printed; byte address is four times the index
  localparam logic [15:0] IDX_PORT0_DIR = 16'hff20;
  localparam logic [15:0] IDX_PRESC_EDGE = 16'hffbb;
  localparam logic [15:0] IDX_OUT_CTRL = 16'hffbd;
  localparam int ADDR_W = 18;
  localparam logic [ADDR_W-1:0] ADDR_PORT0_DIR = {IDX_PORT0_DIR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PRESC_EDGE = {IDX_PRESC_EDGE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_OUT_CTRL = {IDX_OUT_CTRL, 2'b00};

  // Reset values
  localparam logic [7:0] RST_PORT0_DIR = 8'hff;
  localparam logic [7:0] RST_PRESC_EDGE = 8'h00;
  localparam logic [7:0] RST_OUT_CTRL = 8'h00;

  // Output control field positions
  localparam int OC_OUT_EN = 0;
  localparam int OC_INV_FIRST = 1;
  localparam int OC_LVL_CLEAR = 2;
  localparam int OC_LVL_SET = 3;
  localparam int OC_INV_SECOND = 4;
  localparam int OC_ONESHOT_MODE = 5;
  localparam int OC_ONESHOT_TRIG = 6;

  // Prescaler and edge field positions
  localparam int PE_CLK_SEL_LO = 0;
  localparam int PE_IN_A_EDGE_LO = 4;
  localparam int PE_IN_B_EDGE_LO = 6;

  // Port direction: four implemented bits, upper bits read as one
  localparam int PORT0_BITS = 4;
  localparam int SHARED_PIN_BIT = 1;
  localparam logic [7:0] PORT0_UPPER_ONES = 8'hf0;

  // Count clock divide ratios
  localparam int DIV_QUARTER = 4;
  localparam int DIV_SLOW = 256;
  localparam int PRESC_W = 8;

  // Edge field encodings
  localparam logic [1:0] EDGE_FALL = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_BOTH = 2'b11;

  // Count clock field encodings
  localparam logic [1:0] CSEL_SYS = 2'b00;
  localparam logic [1:0] CSEL_QUARTER = 2'b01;
  localparam logic [1:0] CSEL_SLOW = 2'b10;
  localparam logic [1:0] CSEL_EDGE_A = 2'b11;

  typedef enum logic [1:0] {
    TOPC_STOPPED,
    TOPC_FREE_RUN,
    TOPC_CLR_ON_EDGE,
    TOPC_CLR_ON_MATCH
  } topc_mode_e;

  typedef struct packed {
    logic oneshot_mode_enable;
    logic second_match_invert_en;
    logic first_match_invert_en;
    logic out_enable;
  } topc_outctl_s;

  typedef struct packed {
    logic [1:0] in_b_edge;
    logic [1:0] in_a_edge;
    logic [1:0] count_clk_sel;
  } topc_presc_s;

  // Strobes arriving from the counter core
  typedef struct packed {
    logic match_first;
    logic match_second;
    logic overflow;
  } topc_core_ev_s;

endpackage

// >>> topc_edge_det.sv
// Synchroniser and programmable valid-edge detector for one timer input.
// Assumes the pin is asynchronous to sys_clk.
`timescale 1ns/100ps
module topc_edge_det
  import topc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic pin,
  input wire logic enable,
  input wire logic [1:0] edge_sel,
  output logic valid_edge
);

  logic sync_a;
  logic sync_b;
  logic prev;
  logic tracking;
  wire rise = sync_b & ~prev;
  wire fall = ~sync_b & prev;
  wire hit = (edge_sel == EDGE_RISE) ? rise :
             (edge_sel == EDGE_FALL) ? fall :
             (edge_sel == EDGE_BOTH) ? (rise | fall) : 1'b0;

  // Previous level starts low, so a pin already high after reset gives
  // one rising edge on first enable; afterwards it always follows the pin.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
      tracking <= 1'b0;
      valid_edge <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      if (enable | tracking) begin
        prev <= sync_b;
      end
      tracking <= tracking | enable;
      valid_edge <= enable & hit;
    end
  end

endmodule // topc_edge_det

// >>> topc_sva.sv
// Port-level checks for the timer output and prescaler block.
// Assumes one clock domain on sys_clk with async active-low reset_n.
`timescale 1ns/100ps
module topc_sva
  import topc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [2:0] timer_mode_sel,
  input wire topc_core_ev_s core_ev,
  input wire topc_mode_e timer_mode,
  input wire logic count_enable,
  input wire logic oneshot_trigger,
  input wire logic in_a_valid_edge,
  input wire logic timer_output_pin,
  input wire logic [PORT0_BITS-1:0] port0_direction,
  input wire logic output_flipflop
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire rd_done = avs_read && !avs_waitrequest;
  wire trig_wr = wr_done && avs_address == ADDR_OUT_CTRL &&
    avs_writedata[OC_ONESHOT_TRIG];
  wire ff_src = wr_done || core_ev.match_first || core_ev.match_second;
  wire stopped = timer_mode == TOPC_STOPPED;
  wire clr_edge = timer_mode == TOPC_CLR_ON_EDGE;
  wire [1:0] mhi = timer_mode_sel[2:1];
  a_pin_follow: assert property (timer_output_pin |-> output_flipflop)
    else $error("timer pin high with flip-flop low");
  a_pin_moves: assert property ($changed(timer_output_pin) |->
    $changed(output_flipflop) || $past(wr_done))
    else $error("timer pin moved without cause");
  a_mode_decode: assert property (timer_mode == (mhi == 2'h0 ?
    TOPC_STOPPED : mhi == 2'h1 ? TOPC_FREE_RUN : mhi == 2'h2 ?
    TOPC_CLR_ON_EDGE : TOPC_CLR_ON_MATCH))
    else $error("mode decode wrong");
  a_ff_cause: assert property ($changed(output_flipflop) |->
    $past(ff_src)) else $error("flip-flop moved without cause");
  a_stop_quiet: assert property (stopped [*6] |->
    !count_enable && !in_a_valid_edge)
    else $error("activity while stopped");
  a_trig_cause: assert property (oneshot_trigger && !clr_edge |->
    $past(trig_wr)) else $error("trigger without software write");
  a_trig_issue: assert property (trig_wr && !stopped |=>
    oneshot_trigger) else $error("software trigger lost");
  a_rd_ctrl: assert property (rd_done &&
    avs_address == ADDR_OUT_CTRL |-> avs_readdata[7:6] == 2'h0 &&
    avs_readdata[3:2] == 2'h0) else $error("control readback bits set");
  a_rd_dir: assert property (rd_done &&
    avs_address == ADDR_PORT0_DIR |-> avs_readdata[7:0] ==
    {4'hf, port0_direction}) else $error("direction readback wrong");
  c_trig: cover property (oneshot_trigger);
  c_invert: cover property (core_ev.match_second ##1
    $changed(output_flipflop));
  c_edge: cover property (in_a_valid_edge);
endmodule // topc_sva

bind topc_top topc_sva u_sva (.sys_clk, .reset_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .timer_mode_sel, .core_ev, .timer_mode, .count_enable,
  .oneshot_trigger, .in_a_valid_edge, .timer_output_pin, .port0_direction,
  .output_flipflop);

// >>> topc_pulse_src.sv
// Pulse source model for the two asynchronous timer input pins.
// Assumes the bench raises a fire bit to launch one pulse on that pin.
`timescale 1ns/100ps
module topc_pulse_src #(
  parameter int PULSE_W = 4
) (
  input wire logic sys_clk,
  input wire logic [1:0] idle_lvl,
  input wire logic [1:0] fire,
  output logic timer_input_a,
  output logic timer_input_b
);
  // Pulse starts late so the bench warm-up window misses nothing
  localparam int LEAD = 8;
  logic [1:0] fire_q = 2'h0;
  logic [7:0] cnt [2] = '{8'h00, 8'h00};
  logic [1:0] active;
  always @(posedge sys_clk) begin
    fire_q <= fire;
    for (int i = 0; i < 2; i++) begin
      if (fire[i] && !fire_q[i]) begin
        cnt[i] <= 8'(LEAD + PULSE_W);
      end else if (cnt[i] != 8'h00) begin
        cnt[i] <= cnt[i] - 8'h01;
      end
    end
  end
  // Width kept at three or more system clocks
  assign active[0] = cnt[0] != 8'h00 && cnt[0] <= 8'(PULSE_W);
  assign active[1] = cnt[1] != 8'h00 && cnt[1] <= 8'(PULSE_W);
  assign timer_input_a = idle_lvl[0] ^ active[0];
  assign timer_input_b = idle_lvl[1] ^ active[1];
endmodule // topc_pulse_src

// >>> tb_timer_output_prescaler_ctrl.sv
// Self-checking bench for the timer output and prescaler block.
// Assumes topc_top with its bound checker and the pulse source model.
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  failures++; $display("BAD t=%0t got %0h exp %0h", $time, g, e); end end
module tb_timer_output_prescaler_ctrl
  import topc_pkg::*;
;
  localparam int SLOW = 16;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] timer_mode_sel = '0;
  topc_core_ev_s core_ev = '0;
  topc_mode_e timer_mode;
  logic count_enable, oneshot_trigger, in_a_valid_edge, in_b_valid_edge;
  logic timer_input_a, timer_input_b, timer_output_pin, output_flipflop;
  logic [PORT0_BITS-1:0] port0_direction;
  // Input b idles high to show the edge seen right after reset
  logic [1:0] idle_lvl = 2'h2;
  logic [1:0] fire = 2'h0;
  logic [7:0] q;
  int failures = 0;
  int total_checks = 0;
  int ce, ea, eb;

  topc_top #(.DIV_S(SLOW)) u_dut (.sys_clk, .reset_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .timer_mode_sel, .core_ev, .timer_mode, .count_enable,
    .oneshot_trigger, .in_a_valid_edge, .in_b_valid_edge, .timer_input_a,
    .timer_input_b, .timer_output_pin, .port0_direction, .output_flipflop);
  topc_pulse_src #(.PULSE_W(4)) u_src (.sys_clk, .idle_lvl, .fire,
    .timer_input_a, .timer_input_b);

  initial forever #25 sys_clk = ~sys_clk;

  task report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
    input logic [3:0] be);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    avs_read <= !w;
    avs_write <= w;
    // Waitrequest and read data are both taken at the same rising edge
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      failures++;
      report_and_stop();
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'h1);
    `CHK(q, e)
  endtask
  task run(input logic [2:0] m);
    @(posedge sys_clk);
    timer_mode_sel <= m;
  endtask
  task ev(input topc_core_ev_s e);
    @(posedge sys_clk);
    core_ev <= e;
    @(posedge sys_clk);
    core_ev <= '0;
  endtask
  task out_is(input logic f, input logic p);
    @(negedge sys_clk);
    `CHK(output_flipflop, f)
    `CHK(timer_output_pin, p)
  endtask
  // Runs in mode m for n cycles, counting pulses; stops the counter after
  task count(input int n, input logic [1:0] f, input logic [2:0] m);
    @(posedge sys_clk);
    fire <= f;
    timer_mode_sel <= m;
    ce = 0;
    ea = 0;
    eb = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      ce += (i >= 4 && count_enable === 1'b1);
      ea += (in_a_valid_edge === 1'b1);
      eb += (in_b_valid_edge === 1'b1);
    end
    @(posedge sys_clk);
    fire <= 2'h0;
    timer_mode_sel <= 3'h0;
  endtask

  task t_reset;
    @(negedge sys_clk);
    `CHK(port0_direction, 4'hf)
    `CHK(timer_output_pin, 1'b0)
    rd(ADDR_PORT0_DIR, 8'hff);
    rd(ADDR_PRESC_EDGE, 8'h00);
    rd(ADDR_OUT_CTRL, 8'h00);
    rd('0, 8'h00);
  endtask
  task t_first_edge;
    wr(ADDR_PRESC_EDGE, 8'h40);
    count(24, 2'h0, 3'h2);
    `CHK(eb, 1)
    count(24, 2'h0, 3'h2);
    `CHK(eb, 0)
  endtask
  task t_modes;
    topc_mode_e exp [4] = '{TOPC_STOPPED, TOPC_FREE_RUN, TOPC_CLR_ON_EDGE,
      TOPC_CLR_ON_MATCH};
    for (int m = 0; m < 8; m++) begin
      run(3'(m));
      @(negedge sys_clk);
      `CHK(timer_mode, exp[m / 2])
    end
    run(3'h0);
  endtask
  task t_edges;
    logic [1:0] code [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    int exp [4] = '{1, 1, 2, 0};
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_PRESC_EDGE, {code[i], code[i], 4'h0});
      count(40, 2'h3, 3'h2);
      `CHK(ea, exp[i])
      `CHK(eb, exp[i])
    end
  endtask
  task t_clksel;
    int exp [4] = '{64, 16, 64 / SLOW, 1};
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_PRESC_EDGE, 8'h10 | 8'(s));
      count(68, 2'h1, 3'h2);
      `CHK(ce, exp[s])
    end
  endtask
  task t_regs;
    wr(ADDR_PRESC_EDGE, 8'hff);
    rd(ADDR_PRESC_EDGE, 8'hf3);
    wr(ADDR_OUT_CTRL, 8'h73);
    rd(ADDR_OUT_CTRL, 8'h33);
    wr(ADDR_PORT0_DIR, 8'h00);
    rd(ADDR_PORT0_DIR, 8'hf0);
    `CHK(port0_direction, 4'h0)
    bus(1'b1, ADDR_PORT0_DIR, 8'hff, 4'h0);
    wr('0, 8'hff);
    rd(ADDR_PORT0_DIR, 8'hf0);
    wr(ADDR_PRESC_EDGE, 8'h00);
  endtask
  task t_level;
    wr(ADDR_OUT_CTRL, 8'h01);
    wr(ADDR_OUT_CTRL, 8'h09);
    out_is(1'b1, 1'b1);
    rd(ADDR_OUT_CTRL, 8'h01);
    wr(ADDR_OUT_CTRL, 8'h0d);
    out_is(1'b1, 1'b1);
    wr(ADDR_OUT_CTRL, 8'h05);
    out_is(1'b0, 1'b0);
    wr(ADDR_OUT_CTRL, 8'h09);
    wr(ADDR_OUT_CTRL, 8'h00);
    out_is(1'b1, 1'b0);
  endtask
  task t_invert;
    wr(ADDR_OUT_CTRL, 8'h13);
    run(3'h2);
    ev(3'h4);
    out_is(1'b0, 1'b0);
    ev(3'h2);
    out_is(1'b1, 1'b1);
    run(3'h0);
    wr(ADDR_OUT_CTRL, 8'h11);
    run(3'h2);
    ev(3'h4);
    out_is(1'b1, 1'b1);
    ev(3'h2);
    out_is(1'b0, 1'b0);
    wr(ADDR_OUT_CTRL, 8'h01);
    ev(3'h2);
    out_is(1'b0, 1'b0);
    run(3'h0);
  endtask
  task t_oneshot;
    wr(ADDR_OUT_CTRL, 8'h23);
    run(3'h2);
    ev(3'h4);
    out_is(1'b0, 1'b0);
    wr(ADDR_OUT_CTRL, 8'h63);
    @(negedge sys_clk);
    `CHK(oneshot_trigger, 1'b1)
    rd(ADDR_OUT_CTRL, 8'h23);
    ev(3'h4);
    out_is(1'b1, 1'b1);
    ev(3'h1);
    ev(3'h4);
    out_is(1'b1, 1'b1);
    wr(ADDR_OUT_CTRL, 8'h23);
    @(negedge sys_clk);
    `CHK(oneshot_trigger, 1'b0)
    run(3'h0);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_first_edge();
    t_modes();
    t_edges();
    t_clksel();
    t_regs();
    t_level();
    t_invert();
    t_oneshot();
    report_and_stop();
  end
  initial begin
    repeat (50000) @(posedge sys_clk);
    failures++;
    $display("BAD t=%0t timeout", $time);
    report_and_stop();
  end
endmodule // tb_timer_output_prescaler_ctrl
